// *** core/fspr_regs.sv ***
// status and protection register bank, one clock
// assumes the decoder sends one-cycle strobes with op and address range
`timescale 1ns/10ps
module fspr_regs
    import fspr_pkg::*;
#(
    parameter int OP_CYCLES = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              write_guard_pin_n,
    input  wire logic              cmd_write_enable,
    input  wire logic              cmd_write_disable,
    input  wire logic              cmd_start,
    input  wire fspr_op_t          cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_lo,
    input  wire logic [ADDR_W-1:0] cmd_hi,
    input  wire logic [1:0]        cmd_region,
    input  wire logic [15:0]       cmd_status_data,
    input  wire logic              cmd_code_valid,
    input  wire logic [7:0]        cmd_code,
    output logic [7:0]             status_low_byte,
    output logic [7:0]             status_high_byte,
    output logic                   four_lane_command_mode,
    output logic                   write_guard_pin_active,
    output logic                   pause_pin_active,
    output logic                   op_accepted,
    output logic                   op_refused
);
    // the busy counter is 16 bits wide and must count at least one cycle
    if (OP_CYCLES < 1 || OP_CYCLES > 65535) begin : g_bad_cycles
        $error("OP_CYCLES out of range");
    end

    fspr_state_t       state_q;
    logic [15:0]       stat_q;
    logic              quad_q;
    logic [15:0]       cnt_q;
    logic              acc_q;
    logic              ref_q;
    logic              wp_level;
    logic              hits_guard;

    fspr_sync u_sync (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .pin_in    (write_guard_pin_n),
        .level_out (wp_level)
    );

    fspr_range u_range (
        .guard_bits                (stat_q[BIT_BG2:BIT_BG0]),
        .top_bottom_select         (stat_q[BIT_TB]),
        .sector_granularity_select (stat_q[BIT_SEC]),
        .guard_invert              (stat_q[BIT_CMP]),
        .op_lo                     (cmd_lo),
        .op_hi                     (cmd_hi),
        .hits_guard                (hits_guard)
    );

    wire busy              = (state_q == FSPR_WORK);
    wire write_latch_flag  = stat_q[BIT_WEL];
    wire suspend_flag      = stat_q[BIT_SUS];
    wire status_guard_method = stat_q[BIT_SRP];
    wire status_lock       = stat_q[BIT_SRL];
    wire four_lane_enable  = stat_q[BIT_QE];
    wire [3:0] region_lock_bits = stat_q[BIT_LB3:BIT_LB0];

    // guard pin only counts while it is not a data lane
    wire pin_blocks = status_guard_method && !four_lane_enable
                      && !wp_level;
    wire status_ok = write_latch_flag && !pin_blocks && !status_lock;
    wire region_locked = region_lock_bits[cmd_region];
    wire idle_ok = !busy;

    wire start_ok =
        (cmd_op == FSPR_OP_STATUS) ? status_ok :
        (cmd_op == FSPR_OP_SECREG) ? (write_latch_flag && !region_locked) :
        (write_latch_flag && !hits_guard);
    wire do_start  = cmd_start && idle_ok && start_ok;
    wire do_status = do_start && (cmd_op == FSPR_OP_STATUS);

    wire code_suspend = cmd_code_valid && cmd_code == OP_SUSPEND;
    wire code_resume  = cmd_code_valid && cmd_code == OP_RESUME;
    wire code_enter   = cmd_code_valid && cmd_code == OP_ENTER_QUAD;
    wire code_exit    = cmd_code_valid && cmd_code == OP_EXIT_QUAD;

    // new status word for a status write
    logic [15:0] stat_new;
    always_comb begin
        stat_new = (stat_q & ~WRITABLE_MASK)
                 | (cmd_status_data & WRITABLE_MASK);
        stat_new[BIT_LB3:BIT_LB0] = region_lock_bits
                 | cmd_status_data[BIT_LB3:BIT_LB0];
        if (quad_q) begin
            stat_new[BIT_QE] = 1'b1;
        end
        // top/bottom follows the same gate as the whole write
        if (!status_ok) begin
            stat_new[BIT_TB] = stat_q[BIT_TB];
        end
    end

    // state and status word; cleared at power-up through srst
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= FSPR_IDLE;
            stat_q  <= STATUS_RESET;
            cnt_q   <= 16'h0000;
        end else begin
            case (state_q)
                FSPR_IDLE: begin
                    if (do_start) begin
                        state_q <= FSPR_WORK;
                        cnt_q   <= 16'(OP_CYCLES - 1);
                        if (do_status) begin
                            stat_q <= stat_new;
                        end
                        stat_q[BIT_WEL] <= 1'b0;
                    end else if (cmd_write_enable) begin
                        stat_q[BIT_WEL] <= 1'b1;
                    end else if (cmd_write_disable) begin
                        stat_q[BIT_WEL] <= 1'b0;
                    end else if (code_resume) begin
                        stat_q[BIT_SUS] <= 1'b0;
                    end
                end
                FSPR_WORK: begin
                    if (code_suspend) begin
                        state_q         <= FSPR_SUSP;
                        stat_q[BIT_SUS] <= 1'b1;
                    end else if (cnt_q == 16'h0000) begin
                        state_q <= FSPR_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                FSPR_SUSP: begin
                    // reads allowed while suspended; resume continues count
                    if (code_resume) begin
                        state_q         <= FSPR_WORK;
                        stat_q[BIT_SUS] <= 1'b0;
                    end else if (cmd_write_enable) begin
                        stat_q[BIT_WEL] <= 1'b1;
                    end else if (cmd_write_disable) begin
                        stat_q[BIT_WEL] <= 1'b0;
                    end
                end
                default: begin
                    state_q <= FSPR_IDLE;
                end
            endcase
        end
    end

    // four-lane command mode and accept/refuse pulses
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            quad_q <= 1'b0;
            acc_q  <= 1'b0;
            ref_q  <= 1'b0;
        end else begin
            acc_q <= do_start;
            ref_q <= cmd_start && !do_start;
            if (code_enter && four_lane_enable && !busy) begin
                quad_q <= 1'b1;
            end else if (code_exit && !busy) begin
                quad_q <= 1'b0;
            end
        end
    end

    // busy is live state, not stored in the word
    assign status_low_byte  = {stat_q[BIT_SRP:BIT_BG0], stat_q[BIT_WEL],
                               busy};
    assign status_high_byte = stat_q[BIT_SUS:BIT_SRL];
    assign four_lane_command_mode = quad_q;
    assign write_guard_pin_active = !four_lane_enable;
    assign pause_pin_active       = !four_lane_enable;
    assign op_accepted = acc_q;
    assign op_refused  = ref_q;
endmodule

// *** core/fspr_pkg.sv ***
// package for the flash status and protection register bank
// assumes an instruction decoder on clk_sys that issues one-cycle strobes
// Functional notes
// - write enable sets write latch flag
// - latch cleared by disable, program, erase, status write
// - three block guard bits, default zero
// - top_bottom_select zero top, one bottom
// - top_bottom change needs guard method and latch
// - granularity one 4KB sectors, zero 64KB blocks
// - guard_invert swaps guarded and unguarded ranges
// - method zero ignores pin, needs latch only
// - method one and pin low refuses writes
// - method one and pin high needs latch
// - status_lock blocks writes until power cycle
// - suspend instruction sets suspend flag
// - resume or power cycle clears suspend flag
// - region lock bits set once, never cleared; srst clears them
// - locked security region refuses program, erase
// - four_lane_enable disables guard and pause pins
// - enter four-lane mode ignored unless enabled
// - four-lane mode keeps four_lane_enable at one
// - reserved bits read zero, writes ignored
// - busy during program, erase, status write
// - erase/program touching guarded range ignored
package fspr_pkg;
    localparam int ADDR_W = 20;
    localparam int NUM_REGIONS = 4;
    // status word bit positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_BG0 = 2;
    localparam int BIT_BG2 = 4;
    localparam int BIT_TB = 5;
    localparam int BIT_SEC = 6;
    localparam int BIT_SRP = 7;
    localparam int BIT_SRL = 8;
    localparam int BIT_QE = 9;
    localparam int BIT_LB0 = 10;
    localparam int BIT_LB3 = 13;
    localparam int BIT_CMP = 14;
    localparam int BIT_SUS = 15;
    // reserved positions: none beyond those above; kept for clarity
    localparam logic [15:0] WRITABLE_MASK = 16'h7ffc;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // instruction codes
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OP_EXIT_QUAD = 8'hff;
    // array geometry shifts
    localparam int SECTOR_SHIFT = 12;
    localparam int BLOCK_SHIFT = 16;
    localparam logic [19:0] ARRAY_LAST = 20'hf_ffff;
    typedef enum logic [1:0] {
        FSPR_IDLE  = 2'b00,
        FSPR_WORK  = 2'b01,
        FSPR_SUSP  = 2'b10
    } fspr_state_t;
    typedef enum logic [1:0] {
        FSPR_OP_PROG   = 2'b00,
        FSPR_OP_ERASE  = 2'b01,
        FSPR_OP_STATUS = 2'b10,
        FSPR_OP_SECREG = 2'b11
    } fspr_op_t;
endpackage

// *** core/fspr_sync.sv ***
// two-flop synchroniser for a pin level
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/10ps
module fspr_sync (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q    <= 1'b1;
            level_out <= 1'b1;
        end else begin
            meta_q    <= pin_in;
            level_out <= meta_q;
        end
    end
endmodule

// *** core/fspr_range.sv ***
// guarded range decode for the block guard bits
// assumes a 1MB array, range inclusive, combinational
`timescale 1ns/10ps
module fspr_range
    import fspr_pkg::*;
(
    input  wire logic [2:0]        guard_bits,
    input  wire logic              top_bottom_select,
    input  wire logic              sector_granularity_select,
    input  wire logic              guard_invert,
    input  wire logic [ADDR_W-1:0] op_lo,
    input  wire logic [ADDR_W-1:0] op_hi,
    output logic                   hits_guard
);
    logic [ADDR_W:0] span;
    logic [ADDR_W:0] g_lo;
    logic [ADDR_W:0] g_hi;
    logic            none;
    logic            all;
    logic            in_base;
    logic            out_lo;
    logic            out_hi;
    always_comb begin
        none = (guard_bits == 3'd0);
        all  = sector_granularity_select ? (guard_bits == 3'd7)
                                         : (guard_bits >= 3'd5);
        // sector mode caps at 32KB, block mode at half the array
        if (sector_granularity_select) begin
            span = (ADDR_W+1)'(1) << (SECTOR_SHIFT +
                   ((guard_bits[2] ? 3'd4 : guard_bits) - 3'd1));
        end else begin
            span = (ADDR_W+1)'(1) << (BLOCK_SHIFT + guard_bits - 3'd1);
        end
        if (none || all) begin
            span = (ADDR_W+1)'(ARRAY_LAST) + (ADDR_W+1)'(1);
        end
        if (top_bottom_select) begin
            g_lo = '0;
            g_hi = span - (ADDR_W+1)'(1);
        end else begin
            g_lo = (ADDR_W+1)'(ARRAY_LAST) + (ADDR_W+1)'(1) - span;
            g_hi = (ADDR_W+1)'(ARRAY_LAST);
        end
        in_base = !({1'b0, op_hi} < g_lo || {1'b0, op_lo} > g_hi);
        // complement guards what lies outside the base range
        out_lo = ({1'b0, op_lo} < g_lo);
        out_hi = ({1'b0, op_hi} > g_hi);
        if (!guard_invert) begin
            hits_guard = none ? 1'b0 : in_base;
        end else begin
            hits_guard = none ? 1'b1 : (out_lo || out_hi);
        end
    end
endmodule

// *** verif/fspr_regs_properties.sv ***
// checker for the status and protection bank, sees top ports only
// assumes the bench keeps OP_CYCLES at 2 or more
`timescale 1ns/10ps
module fspr_regs_properties
    import fspr_pkg::*;
#(
    parameter int OP_CYCLES = 16
) (
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic       cmd_write_enable,
    input wire logic       cmd_start,
    input wire fspr_op_t   cmd_op,
    input wire logic       cmd_code_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] status_low_byte,
    input wire logic [7:0] status_high_byte,
    input wire logic       four_lane_command_mode,
    input wire logic       write_guard_pin_active,
    input wire logic       pause_pin_active,
    input wire logic       op_accepted,
    input wire logic       op_refused
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    latch_set_a: assert property (cmd_write_enable && !cmd_start
        && !status_low_byte[0] |=> status_low_byte[1]) else $error("latch not set");
    latch_clear_a: assert property (op_accepted |->
        !status_low_byte[1]) else $error("latch kept after start");
    busy_run_a: assert property (op_accepted |->
        status_low_byte[0] ##1 status_low_byte[0]) else $error("busy too short");
    no_latch_a: assert property (cmd_start && !status_low_byte[1]
        |=> op_refused && !op_accepted) else $error("start without latch");
    lock_down_a: assert property (cmd_start && status_high_byte[0]
        && cmd_op == FSPR_OP_STATUS |=> !op_accepted)
        else $error("write taken while locked");
    pin_funcs_a: assert property (write_guard_pin_active ==
        !status_high_byte[1] && pause_pin_active == !status_high_byte[1])
        else $error("pin functions wrong");
    quad_qe_a: assert property (four_lane_command_mode |->
        status_high_byte[1]) else $error("qe low in quad mode");
    quad_entry_a: assert property (cmd_code_valid &&
        cmd_code == OP_ENTER_QUAD && !status_high_byte[1]
        |=> !four_lane_command_mode) else $error("quad entered without qe");
    suspend_set_a: assert property (cmd_code_valid &&
        cmd_code == OP_SUSPEND && status_low_byte[0]
        |=> status_high_byte[7]) else $error("suspend flag not set");
    resume_clear_a: assert property (cmd_code_valid &&
        cmd_code == OP_RESUME |=> !status_high_byte[7])
        else $error("suspend flag not cleared");
    lock_keep_a: assert property (1'b1 |=> (status_high_byte[5:2] &
        $past(status_high_byte[5:2])) == $past(status_high_byte[5:2]))
        else $error("region lock fell");
    cover property (op_accepted);
    cover property (op_refused);
    cover property (four_lane_command_mode);
endmodule

bind fspr_regs fspr_regs_properties #(.OP_CYCLES(OP_CYCLES))
    i_fspr_regs_properties (.*);

// *** verif/fspr_host_model.sv ***
// host model: issues status instructions as decoder strobes
// assumes fspr_regs on clk_sys; drives at the falling edge
`timescale 1ns/10ps
module fspr_host_model
    import fspr_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   busy,
    input  wire logic   op_accepted,
    output logic        cmd_write_enable = 1'b0,
    output logic        cmd_write_disable = 1'b0,
    output logic        cmd_start = 1'b0,
    output fspr_op_t    cmd_op = FSPR_OP_PROG,
    output logic [19:0] cmd_lo = 20'h0_0000,
    output logic [19:0] cmd_hi = 20'h0_0000,
    output logic [1:0]  cmd_region = 2'h0,
    output logic [15:0] cmd_status_data = 16'h0000,
    output logic        cmd_code_valid = 1'b0,
    output logic [7:0]  cmd_code = 8'h00
);
    task automatic wren(input logic dis);
        @(negedge clk_sys);
        cmd_write_enable = !dis;
        cmd_write_disable = dis;
        @(negedge clk_sys);
        cmd_write_enable = 1'b0;
        cmd_write_disable = 1'b0;
    endtask
    task automatic code(input logic [7:0] c);
        @(negedge clk_sys);
        cmd_code_valid = 1'b1;
        cmd_code = c;
        @(negedge clk_sys);
        cmd_code_valid = 1'b0;
        cmd_code = ~c;
    endtask
    task automatic start(input fspr_op_t o, input logic [19:0] lo,
                         input logic [15:0] d, output logic acc);
        @(negedge clk_sys);
        cmd_start = 1'b1;
        cmd_op = o;
        cmd_lo = lo;
        cmd_hi = lo + 20'h0_00ff;
        cmd_region = lo[1:0];
        cmd_status_data = d;
        @(negedge clk_sys);
        acc = op_accepted;
        cmd_start = 1'b0;
        // released lines must not look held
        cmd_lo = ~lo;
        cmd_status_data = ~d;
    endtask
    task automatic op(input fspr_op_t o, input logic [19:0] lo,
                      input logic [15:0] d, output logic acc);
        wren(1'b0);
        start(o, lo, d, acc);
        for (int i = 0; i < 40 && busy !== 1'b0; i++)
            @(negedge clk_sys);
    endtask
endmodule

// *** verif/tb_top.sv ***
// bench for the status and protection bank
// assumes fspr_host_model as the host; one clock, sync reset
`timescale 1ns/10ps
module tb_top;
    import fspr_pkg::*;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        write_guard_pin_n = 1'b0;
    logic        acc;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic        cmd_write_enable, cmd_write_disable, cmd_start;
    logic        cmd_code_valid, four_lane_command_mode;
    logic        write_guard_pin_active, pause_pin_active;
    logic        op_accepted, op_refused;
    fspr_op_t    cmd_op;
    logic [19:0] cmd_lo, cmd_hi;
    logic [1:0]  cmd_region;
    logic [15:0] cmd_status_data;
    logic [7:0]  cmd_code, status_low_byte, status_high_byte;
    wire  [15:0] st = {status_high_byte, status_low_byte};
    // guard settings and targets; odd entries lie outside the range
    logic [15:0] tw [8] = '{16'h000c, 16'h000c, 16'h400c, 16'h400c,
        16'h002c, 16'h002c, 16'h006c, 16'h006c};
    logic [19:0] ta [8] = '{20'hc_0000, 20'hb_0000, 20'hb_0000,
        20'hc_0000, 20'h0_0000, 20'hc_0000, 20'h0_3000, 20'h0_4000};
    fspr_regs #(.OP_CYCLES(8)) i_fspr_regs (.clk_sys, .srst,
        .write_guard_pin_n, .cmd_write_enable, .cmd_write_disable,
        .cmd_start, .cmd_op, .cmd_lo, .cmd_hi, .cmd_region,
        .cmd_status_data, .cmd_code_valid, .cmd_code, .status_low_byte,
        .status_high_byte, .four_lane_command_mode,
        .write_guard_pin_active, .pause_pin_active, .op_accepted,
        .op_refused);
    fspr_host_model i_fspr_host_model (.clk_sys,
        .busy(status_low_byte[0]), .op_accepted, .cmd_write_enable,
        .cmd_write_disable, .cmd_start, .cmd_op, .cmd_lo, .cmd_hi,
        .cmd_region, .cmd_status_data, .cmd_code_valid, .cmd_code);
    always #10 clk_sys = ~clk_sys;
    task automatic print_verdict;
        $display("checks=%0d fails=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input fspr_op_t o, input logic [19:0] lo,
                       input logic [15:0] d, input logic exp);
        i_fspr_host_model.op(o, lo, d, acc);
        chk(16'(acc), 16'(exp));
    endtask
    // about 300 cycles expected; a hang stops well past that
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        chk(st, 16'h0000);
        i_fspr_host_model.wren(1'b0);
        chk(st, 16'h0002);
        i_fspr_host_model.wren(1'b1);
        chk(st, 16'h0000);
        i_fspr_host_model.start(FSPR_OP_STATUS, 20'h0_0000, 16'h0004, acc);
        chk(16'(acc), 16'h0000);
        i_fspr_host_model.wren(1'b0);
        i_fspr_host_model.start(FSPR_OP_STATUS, 20'h0_0000, 16'h842f, acc);
        chk(st[15:0] & 16'h0003, 16'h0001);
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h842f, 1'b0);
        chk(st, 16'h042c);
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h0000, 1'b1);
        chk(st, 16'h0400);
        for (int i = 0; i < 8; i++) begin
            run(FSPR_OP_STATUS, 20'h0_0000, tw[i], 1'b1);
            run(i[1] ? FSPR_OP_ERASE : FSPR_OP_PROG, ta[i], 16'h0000,
                i[0]);
        end
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h0000, 1'b1);
        run(FSPR_OP_SECREG, 20'h0_0000, 16'h0000, 1'b0);
        run(FSPR_OP_SECREG, 20'h0_0001, 16'h0000, 1'b1);
        i_fspr_host_model.code(OP_ENTER_QUAD);
        chk(16'(four_lane_command_mode), 16'h0000);
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h0200, 1'b1);
        chk(16'({write_guard_pin_active, pause_pin_active}),
            16'h0000);
        i_fspr_host_model.code(OP_ENTER_QUAD);
        chk(16'(four_lane_command_mode), 16'h0001);
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h0000, 1'b1);
        chk(st, 16'h0600);
        i_fspr_host_model.code(OP_EXIT_QUAD);
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h0000, 1'b1);
        chk(16'({write_guard_pin_active, pause_pin_active}),
            16'h0003);
        i_fspr_host_model.wren(1'b0);
        i_fspr_host_model.start(FSPR_OP_PROG, 20'h1_0000, 16'h0000, acc);
        chk(16'(acc), 16'h0001);
        i_fspr_host_model.code(OP_SUSPEND);
        chk(16'(st[15]), 16'h0001);
        i_fspr_host_model.code(OP_RESUME);
        chk(16'(st[15]), 16'h0000);
        // resumed work must finish before the next write enable is heard
        while (status_low_byte[0] !== 1'b0) @(negedge clk_sys);
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h0080, 1'b1);
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h0000, 1'b0);
        write_guard_pin_n = 1'b1;
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h0100, 1'b1);
        run(FSPR_OP_STATUS, 20'h0_0000, 16'h0000, 1'b0);
        chk(st, 16'h0502);
        srst = 1'b1;
        @(negedge clk_sys);
        srst = 1'b0;
        chk(st, 16'h0000);
        print_verdict();
    end
endmodule
